// ### logic/xum_pkg.sv
// Purpose: constants and carriers for the extension unlock and misc control bank
// Assumes: indexed access through the sequencer data port, 8-bit data
// Notes: indices are the printed register indices
//
// Behaviour
// - access field xxx1x010 unlocks extensions; unlock register reads 12h
// - any other access value locks extensions; unlock register reads 0fh
// - reserved and unused bits reset to zero
// - memory data lines 14..12 captured at reset into mode bits 6..4
// - mode bit 0 set gives eight pixels per character clock
// - mode bit 0 set gives packed-pixel consecutive addressing
// - otherwise no packed addressing; chain-4 uses every fourth address
// - symmetrical addressing bit resets from dual column-strobe strap
// - strap high resets symmetrical bit to one
// - strap low resets symmetrical bit to zero
// - misc bit 6 set suppresses the 16-bit memory chip select
// - misc bits 2..0 read switch inputs three to one
// - misc bit 3 selects suspend polarity, zero active high
`default_nettype none
package xum_pkg;
  localparam logic [7:0] IDX_UNLOCK = 8'h06;
  localparam logic [7:0] IDX_MODE = 8'h07;
  localparam logic [7:0] IDX_MISC = 8'h08;
  localparam logic [7:0] UNLOCK_READ = 8'h12;
  localparam logic [7:0] LOCK_READ = 8'h0f;
  localparam logic [4:0] UNLOCK_MASK = 5'h17;
  localparam logic [4:0] UNLOCK_VAL = 5'h12;
  localparam logic [4:0] ACCESS_RESET = 5'h00;
  localparam int MODE_PACKED_BIT = 0;
  localparam int MODE_SENSE_LSB = 4;
  localparam int MISC_SYM_BIT = 7;
  localparam int MISC_NOCS16_BIT = 6;
  localparam int MISC_STBY_BIT = 5;
  localparam int MISC_BKLT_BIT = 4;
  localparam int MISC_SUSP_BIT = 3;
  localparam logic [3:0] PIX_PER_CHAR_PACKED = 4'h8;
  localparam logic [3:0] PIX_PER_CHAR_NORMAL = 4'h4;
  localparam logic [2:0] ADDR_STEP_PACKED = 3'h1;
  localparam logic [2:0] ADDR_STEP_CHAIN4 = 3'h4;
  localparam logic [2:0] ADDR_STEP_PLANAR = 3'h1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } xum_req_t;

  typedef struct packed {
    logic sym_addr;
    logic nocs16;
    logic rst_standby;
    logic rst_backlight;
    logic susp_low;
    logic packed_pix;
  } xum_ctrl_t;
endpackage : xum_pkg
`default_nettype wire

// ### logic/xum_regs.sv
// Purpose: extension unlock, extended mode and miscellaneous control registers
// Assumes: one-cycle wr/rd strobes with index from the sequencer port decode
// Notes: read data is registered, valid the cycle after rd
`timescale 1ns/1ps
`default_nettype none
module xum_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire xum_pkg::xum_req_t req,
  output logic [7:0] rdata,
  input wire logic [2:0] memory_data_sense_lines,
  input wire logic dual_column_strobe_select,
  input wire logic switch_input_one,
  input wire logic switch_input_two,
  input wire logic switch_input_three,
  input wire logic suspend_pin,
  input wire logic mem_access,
  input wire logic chain4_mode,
  output xum_pkg::xum_ctrl_t ctrl,
  output logic ext_unlocked,
  output logic [3:0] pix_per_char,
  output logic [2:0] addr_step,
  output logic memcs16_req,
  output logic suspend_active
);
  import xum_pkg::*;

  logic [1:0] rst_sync_ff;
  logic [1:0] fill_ff;
  logic srst_n;
  logic [2:0] sense_s;
  logic [2:0] sw_s;
  logic strap_s;
  logic susp_s;
  logic [4:0] access_ff;
  logic unlocked;
  logic [2:0] sense_ff;
  logic sense_taken_ff;
  logic packed_ff;
  logic sym_ff;
  logic sym_taken_ff;
  logic nocs16_ff;
  logic stby_ff;
  logic bklt_ff;
  logic susp_low_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] ppc_ff;
  logic [2:0] step_ff;
  logic cs16_ff;
  logic susp_act_ff;

  function automatic logic is_unlock(input logic [4:0] v);
    is_unlock = (v & UNLOCK_MASK) == UNLOCK_VAL;
  endfunction : is_unlock

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_ff[1];

  // the synchroniser shows zeros for two edges after release; straps wait for real levels
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      fill_ff <= 2'h0;
    end else begin
      fill_ff <= {fill_ff[0], 1'b1};
    end
  end

  xum_sync #(.W(8)) u_sync (
    .core_clk(core_clk),
    .rst_n(srst_n),
    .d({memory_data_sense_lines, switch_input_three, switch_input_two,
        switch_input_one, dual_column_strobe_select, suspend_pin}),
    .q({sense_s, sw_s, strap_s, susp_s})
  );

  assign unlocked = is_unlock(access_ff);

  // access field stores bits 4..0 of any written value
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      access_ff <= ACCESS_RESET;
    end else if (req.wr && req.idx == IDX_UNLOCK) begin
      access_ff <= req.wdata[4:0];
    end
  end

  // straps caught once the synchronised level is valid after release
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      sense_ff <= 3'h0;
      sense_taken_ff <= 1'b0;
    end else if (!sense_taken_ff && fill_ff[1]) begin
      sense_ff <= sense_s;
      sense_taken_ff <= 1'b1;
    end
  end

  // packed-pixel select; locked writes ignored
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      packed_ff <= 1'b0;
    end else if (req.wr && unlocked && req.idx == IDX_MODE) begin
      packed_ff <= req.wdata[MODE_PACKED_BIT];
    end
  end

  // symmetrical addressing reset value follows the strap
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      sym_ff <= 1'b0;
      sym_taken_ff <= 1'b0;
    end else if (req.wr && unlocked && req.idx == IDX_MISC) begin
      sym_ff <= req.wdata[MISC_SYM_BIT];
      sym_taken_ff <= 1'b1;
    end else if (!sym_taken_ff && fill_ff[1]) begin
      sym_ff <= strap_s;
      sym_taken_ff <= 1'b1;
    end
  end

  // remaining misc control bits
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      nocs16_ff <= 1'b0;
      stby_ff <= 1'b0;
      bklt_ff <= 1'b0;
      susp_low_ff <= 1'b0;
    end else if (req.wr && unlocked && req.idx == IDX_MISC) begin
      nocs16_ff <= req.wdata[MISC_NOCS16_BIT];
      stby_ff <= req.wdata[MISC_STBY_BIT];
      bklt_ff <= req.wdata[MISC_BKLT_BIT];
      susp_low_ff <= req.wdata[MISC_SUSP_BIT];
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    case (req.idx)
      IDX_UNLOCK: nxt_rdata = unlocked ? UNLOCK_READ : LOCK_READ;
      IDX_MODE: begin
        if (unlocked) begin
          nxt_rdata = {1'b0, sense_ff, 3'h0, packed_ff};
        end
      end
      IDX_MISC: begin
        if (unlocked) begin
          nxt_rdata = {sym_ff, nocs16_ff, stby_ff, bklt_ff, susp_low_ff, sw_s};
        end
      end
      default: nxt_rdata = 8'h00;
    endcase
  end

  // locked reads of other extensions give zero
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // display pipeline steering
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      ppc_ff <= PIX_PER_CHAR_NORMAL;
      step_ff <= ADDR_STEP_PLANAR;
    end else if (packed_ff) begin
      ppc_ff <= PIX_PER_CHAR_PACKED;
      step_ff <= ADDR_STEP_PACKED;
    end else begin
      ppc_ff <= PIX_PER_CHAR_NORMAL;
      step_ff <= chain4_mode ? ADDR_STEP_CHAIN4 : ADDR_STEP_PLANAR;
    end
  end

  // chip select suppressed for display memory; polarity
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      cs16_ff <= 1'b0;
      susp_act_ff <= 1'b0;
    end else begin
      cs16_ff <= mem_access && !nocs16_ff;
      susp_act_ff <= susp_low_ff ? !susp_s : susp_s;
    end
  end

  assign rdata = rdata_ff;
  assign ext_unlocked = unlocked;
  assign pix_per_char = ppc_ff;
  assign addr_step = step_ff;
  assign memcs16_req = cs16_ff;
  assign suspend_active = susp_act_ff;
  assign ctrl = '{sym_addr: sym_ff, nocs16: nocs16_ff, rst_standby: stby_ff,
                  rst_backlight: bklt_ff, susp_low: susp_low_ff, packed_pix: packed_ff};

  property p_unlock_read;
    @(posedge core_clk) disable iff (!srst_n)
      req.rd && req.idx == IDX_UNLOCK |=> rdata == ($past(unlocked) ? UNLOCK_READ : LOCK_READ);
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("unlock readback wrong");

  property p_lock_after_bad;
    @(posedge core_clk) disable iff (!srst_n)
      req.wr && req.idx == IDX_UNLOCK && (req.wdata[4:0] & UNLOCK_MASK) != UNLOCK_VAL
      |=> !ext_unlocked;
  endproperty
  a_lock_after_bad: assert property (p_lock_after_bad) else $error("not locked");

  property p_locked_read_zero;
    @(posedge core_clk) disable iff (!srst_n)
      req.rd && !unlocked && req.idx != IDX_UNLOCK |=> rdata == 8'h00;
  endproperty
  a_locked_read_zero: assert property (p_locked_read_zero) else $error("locked read");

  property p_locked_write;
    @(posedge core_clk) disable iff (!srst_n)
      req.wr && !unlocked && req.idx == IDX_MODE |=> $stable(packed_ff);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write took");

  property p_sense;
    @(posedge core_clk) disable iff (!srst_n)
      $rose(sense_taken_ff) |-> sense_ff == $past(sense_s);
  endproperty
  a_sense: assert property (p_sense) else $error("sense strap not latched");

  property p_packed;
    @(posedge core_clk) disable iff (!srst_n)
      packed_ff ##1 packed_ff |-> pix_per_char == PIX_PER_CHAR_PACKED
        && addr_step == ADDR_STEP_PACKED;
  endproperty
  a_packed: assert property (p_packed) else $error("packed mode not applied");

  property p_chain4;
    @(posedge core_clk) disable iff (!srst_n)
      !packed_ff && chain4_mode |=> addr_step == ADDR_STEP_CHAIN4;
  endproperty
  a_chain4: assert property (p_chain4) else $error("chain4 step wrong");

  property p_strap;
    @(posedge core_clk) disable iff (!srst_n)
      $rose(sym_taken_ff) && !$past(req.wr) |-> sym_ff == $past(strap_s);
  endproperty
  a_strap: assert property (p_strap) else $error("strap reset value wrong");

  property p_cs16;
    @(posedge core_clk) disable iff (!srst_n)
      mem_access && nocs16_ff |=> !memcs16_req;
  endproperty
  a_cs16: assert property (p_cs16) else $error("cs16 not suppressed");

  property p_susp;
    @(posedge core_clk) disable iff (!srst_n)
      1'b1 |=> suspend_active == ($past(susp_low_ff) ^ $past(susp_s));
  endproperty
  a_susp: assert property (p_susp) else $error("suspend polarity wrong");

  property p_switch;
    @(posedge core_clk) disable iff (!srst_n)
      req.rd && unlocked && req.idx == IDX_MISC |=> rdata[2:0] == $past(sw_s);
  endproperty
  a_switch: assert property (p_switch) else $error("switch read wrong");

  property p_unlock_write;
    @(posedge core_clk) disable iff (!srst_n)
      req.wr && req.idx == IDX_UNLOCK && (req.wdata[4:0] & UNLOCK_MASK) == UNLOCK_VAL
      |=> ext_unlocked;
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("not unlocked");

  property p_mode_write;
    @(posedge core_clk) disable iff (!srst_n)
      req.wr && unlocked && req.idx == IDX_MODE |=> packed_ff == $past(req.wdata[0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_packed_step;
    @(posedge core_clk) disable iff (!srst_n)
      packed_ff |=> addr_step == ADDR_STEP_PACKED;
  endproperty
  a_packed_step: assert property (p_packed_step) else $error("packed step wrong");

  property p_planar;
    @(posedge core_clk) disable iff (!srst_n)
      !packed_ff && !chain4_mode |=> addr_step == ADDR_STEP_PLANAR
        && pix_per_char == PIX_PER_CHAR_NORMAL;
  endproperty
  a_planar: assert property (p_planar) else $error("planar steering wrong");

  property p_cs16_pass;
    @(posedge core_clk) disable iff (!srst_n)
      mem_access && !nocs16_ff |=> memcs16_req;
  endproperty
  a_cs16_pass: assert property (p_cs16_pass) else $error("cs16 missing");

  // the strap may still land during a locked write, so only check once it is taken
  property p_locked_misc;
    @(posedge core_clk) disable iff (!srst_n)
      req.wr && !unlocked && req.idx == IDX_MISC && sym_taken_ff |=> $stable(ctrl);
  endproperty
  a_locked_misc: assert property (p_locked_misc) else $error("locked misc write took");

  property p_sense_hold;
    @(posedge core_clk) disable iff (!srst_n)
      sense_taken_ff |=> $stable(sense_ff);
  endproperty
  a_sense_hold: assert property (p_sense_hold) else $error("sense strap changed");
endmodule : xum_regs
`default_nettype wire

// ### logic/xum_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: pins are asynchronous to core_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module xum_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : xum_sync
`default_nettype wire

// ### verification/extension_unlock_and_misc_control_tb_top.sv
// Purpose: self-checking bench for the extension unlock and misc control bank
// Assumes: one-cycle wr/rd strobes driven at the falling edge, straps steady over reset
// Notes: expectations are built from the register layout, never read back from the design
`timescale 1ns/1ps
`default_nettype none
module extension_unlock_and_misc_control_tb_top;
  import xum_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  xum_req_t req = '0;
  logic [7:0] rdata;
  logic [2:0] sense = 3'h5;
  logic strap = 1'b1;
  logic [2:0] sw = 3'h5;
  logic susp_pin = 1'b0;
  logic mem_access = 1'b0;
  logic chain4 = 1'b0;
  xum_ctrl_t ctrl;
  logic ext_unlocked;
  logic memcs16_req;
  logic suspend_active;
  logic [3:0] pix_per_char;
  logic [2:0] addr_step;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] vals [6] = '{8'h12, 8'h02, 8'hfa, 8'h13, 8'h16, 8'h1a};
  logic ok;

  always #50 core_clk = ~core_clk;

  xum_regs u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .memory_data_sense_lines(sense), .dual_column_strobe_select(strap),
    .switch_input_one(sw[0]), .switch_input_two(sw[1]), .switch_input_three(sw[2]),
    .suspend_pin(susp_pin), .mem_access(mem_access), .chain4_mode(chain4),
    .ctrl(ctrl), .ext_unlocked(ext_unlocked), .pix_per_char(pix_per_char),
    .addr_step(addr_step), .memcs16_req(memcs16_req), .suspend_active(suspend_active)
  );

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // settle time covers the registered outputs that follow a register one edge late
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
    @(negedge core_clk);
    req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: data};
    @(negedge core_clk);
    req = '0;
    repeat (2) @(negedge core_clk);
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge core_clk);
    req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
    @(negedge core_clk);
    req = '0;
    @(negedge core_clk);
    chk(rdata, exp, "read data");
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc

  // straps must stay put until the sense latch has taken them
  task automatic do_reset();
    rst_n = 1'b0;
    wait_cyc(8);
    rst_n = 1'b1;
    wait_cyc(8);
  endtask : do_reset

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    do_reset();
    chk({2'b00, ctrl}, 8'h20, "ctrl after reset");
    chk({4'h0, pix_per_char}, 8'h04, "pixels per char");
    rd_chk(IDX_UNLOCK, 8'h0f);
    reg_wr(IDX_MODE, 8'h01);
    chk({4'h0, pix_per_char}, 8'h04, "locked mode write");
    for (int i = 0; i < 6; i++) begin
      ok = (vals[i][4:0] & 5'h17) == 5'h12;
      reg_wr(IDX_UNLOCK, vals[i]);
      chk({7'h00, ext_unlocked}, {7'h00, ok}, "unlock state");
      rd_chk(IDX_UNLOCK, ok ? 8'h12 : 8'h0f);
      rd_chk(IDX_MODE, ok ? 8'h50 : 8'h00);
    end
    reg_wr(IDX_MODE, 8'hff);
    rd_chk(IDX_MODE, 8'h51);
    chk({4'h0, pix_per_char}, 8'h08, "packed pixels");
    chain4 = 1'b1;
    wait_cyc(2);
    chk({5'h00, addr_step}, 8'h01, "packed step");
    reg_wr(IDX_MODE, 8'h00);
    chk({5'h00, addr_step}, 8'h04, "chain4 step");
    chk({4'h0, pix_per_char}, 8'h04, "normal pixels");
    chain4 = 1'b0;
    wait_cyc(2);
    chk({5'h00, addr_step}, 8'h01, "planar step");
    rd_chk(IDX_MISC, 8'h85);
    sw = 3'h2;
    wait_cyc(4);
    rd_chk(IDX_MISC, 8'h82);
    reg_wr(IDX_MISC, 8'h4d);
    rd_chk(IDX_MISC, 8'h4a);
    mem_access = 1'b1;
    wait_cyc(2);
    chk({7'h00, memcs16_req}, 8'h00, "cs16 suppressed");
    chk({7'h00, suspend_active}, 8'h01, "suspend low active");
    reg_wr(IDX_MISC, 8'h00);
    chk({7'h00, memcs16_req}, 8'h01, "cs16 active");
    chk({7'h00, suspend_active}, 8'h00, "suspend high idle");
    susp_pin = 1'b1;
    wait_cyc(4);
    chk({7'h00, suspend_active}, 8'h01, "suspend high active");
    reg_wr(IDX_UNLOCK, 8'h00);
    reg_wr(IDX_MISC, 8'hc0);
    rd_chk(IDX_MISC, 8'h00);
    chk({2'b00, ctrl}, 8'h00, "locked misc write");
    strap = 1'b0;
    sense = 3'h2;
    do_reset();
    chk({2'b00, ctrl}, 8'h00, "ctrl strap low");
    reg_wr(IDX_UNLOCK, 8'h12);
    rd_chk(IDX_MODE, 8'h20);
    rd_chk(IDX_MISC, 8'h02);
    reg_wr(IDX_MISC, 8'h80);
    rd_chk(IDX_MISC, 8'h82);
    results();
  end
endmodule : extension_unlock_and_misc_control_tb_top
`default_nettype wire
